// [rtl/adc_result_format_and_bias.sv]
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "adc_fmt_defines.svh"
module adc_result_format_and_bias
  #(parameter int RAW_W = 20)
  (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Modulator side: raw signed accumulator with a done strobe
  input  wire logic               raw_valid,
  input  wire logic [RAW_W-1:0]   raw_value,
  // Analog controls and result flag
  output logic                    chain_enable,
  output logic [1:0]              converter_bias_select,
  output logic [1:0]              amplifier_bias_select,
  output logic [2:0]              oversampling_select,
  output logic [1:0]              elementary_count_select,
  output logic                    result_ready
  );
  import adc_fmt_pkg::*;

  // ==========================================================
  // Helper functions
  // ==========================================================
  // Effective resolution in bits, limited by the width of the result.
  function automatic logic [4:0] resolution(input logic [2:0] osr_sel,
                                            input logic [1:0] nelc_sel);
    logic [5:0] n;
    n = 6'(2 * (`OSR_BASE_EXP + osr_sel)) + 6'(nelc_sel);
    if (n > 6'(`RES_MAX_BITS))
      resolution = `RES_MAX_BITS;
    else
      resolution = n[4:0];
  endfunction

  // Highest allowed sampling rate per bias code, in half-kHz steps, so
  // that the lowest limit stays a whole number.
  function automatic logic [9:0] rate_khz_x2(input logic [1:0] b);
    rate_khz_x2 = `RATE_Q_KHZ_BASE << b;
  endfunction

  // The accumulator is wider than the result, so anything beyond the
  // two full-scale codes is clamped rather than wrapped; a wrapped code
  // would flip sign and look like a reading at the far end of the range.
  function automatic logic [15:0] saturate(input logic [RAW_W-1:0] v);
    logic signed [RAW_W-1:0] s;
    s = $signed(v);
    if (s > $signed(RAW_W'($signed(`CODE_POS_FULL))))
      saturate = `CODE_POS_FULL;
    else if (s < $signed({{(RAW_W-15){1'b1}}, 15'h0000}))
      saturate = `CODE_NEG_FULL;
    else
      saturate = v[15:0];
  endfunction

  // Bits below the effective resolution carry no information; a fixed
  // one-then-zeros pattern places the code in the middle of its step.
  function automatic logic [15:0] force_lsbs(input logic [15:0] code,
                                             input logic [4:0] n);
    logic [15:0] keep;
    logic [15:0] pat;
    logic [4:0]  k;
    k = `RES_MAX_BITS - n;
    keep = 16'hFFFF << k;
    pat = (k == 5'd0) ? 16'h0000 : (16'h0001 << (k - 5'd1));
    force_lsbs = (code & keep) | pat;
  endfunction

  // ==========================================================
  // Control register
  // ==========================================================
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic        wr_en;
  logic        rd_en;

  // Reads are decoded in the setup phase, so prdata is already held in
  // its flop when the access phase is sampled and no wait state is needed.
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // Unused control bits are stored and read back as written, which keeps
  // the register a plain store for software.
  always_comb
  begin
    ctrl_d = ctrl_q;
    if (wr_en && paddr == `ADDR_CTRL)
      ctrl_d = pwdata;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_q <= `CTRL_RESET;
    else
      ctrl_q <= ctrl_d;
  end

  // ==========================================================
  // Control field decode
  // ==========================================================
  logic [2:0] osr_sel;
  logic [1:0] nelc_sel;
  logic [1:0] cbias;
  logic [1:0] abias;
  logic       en;
  assign osr_sel  = ctrl_q[`CTRL_OSR_LSB +: 3];
  assign nelc_sel = ctrl_q[`CTRL_NELC_LSB +: 2];
  assign cbias    = ctrl_q[`CTRL_CBIAS_LSB +: 2];
  assign abias    = ctrl_q[`CTRL_ABIAS_LSB +: 2];
  assign en       = ctrl_q[`CTRL_ENABLE_BIT];

  // ==========================================================
  // Result capture
  // ==========================================================
  // The word is latched as a whole at conversion end so a byte pair
  // read between conversions always belongs to one conversion.
  conv_state_t state_q;
  conv_state_t state_d;
  logic [15:0] result_q;
  logic [15:0] result_d;
  logic        fresh_q;
  logic        fresh_d;

  always_comb
  begin
    state_d  = state_q;
    result_d = result_q;
    fresh_d  = fresh_q;
    case (state_q)
      ST_IDLE:
        if (en)
          state_d = ST_CONV;
      ST_CONV:
        if (!en)
          state_d = ST_IDLE;
        else if (raw_valid)
          state_d = ST_DONE;
      // One cycle in DONE ignores the strobe, so two strobes back to
      // back cannot replace the word before it has been seen.
      ST_DONE:
        state_d = en ? ST_CONV : ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
    // A capture in the same cycle as a low-byte read keeps the flag set,
    // so a fresh result is never reported as already read.
    if (state_q == ST_CONV && en && raw_valid)
    begin
      result_d = force_lsbs(saturate(raw_value),
                            resolution(osr_sel, nelc_sel));
      fresh_d  = 1'b1;
    end
    else if (rd_en && paddr == `ADDR_RESULT_LOW)
      fresh_d = 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q  <= ST_IDLE;
      result_q <= 16'h0000;
      fresh_q  <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      result_q <= result_d;
      fresh_q  <= fresh_d;
    end
  end

  // ==========================================================
  // APB read path and outputs
  // ==========================================================
  logic [31:0] rdata_d;
  logic        err_d;
  logic [9:0]  lim;

  // Status shows the slower of the two bias limits, which is the rate
  // software must stay under whatever the other setting allows.
  function automatic logic [9:0] slower_limit(input logic [1:0] b0,
                                              input logic [1:0] b1);
    logic [9:0] r0;
    logic [9:0] r1;
    r0 = rate_khz_x2(b0);
    r1 = rate_khz_x2(b1);
    slower_limit = (r0 < r1) ? r0 : r1;
  endfunction

  assign lim = slower_limit(cbias, abias);

  // A write to anything but the control word is refused in its setup
  // phase, and the error is held through the access phase it belongs to.
  always_comb
  begin
    rdata_d = prdata;
    err_d   = 1'b0;
    if (rd_en)
    begin
      case (paddr)
        `ADDR_CTRL:        rdata_d = ctrl_q;
        `ADDR_RESULT_HIGH: rdata_d = {24'h00_0000, result_q[15:8]};
        `ADDR_RESULT_LOW:  rdata_d = {24'h00_0000, result_q[7:0]};
        `ADDR_RESULT_WORD: rdata_d = {16'h0000, result_q};
        `ADDR_STATUS:
          rdata_d = {11'h000,
                     resolution(osr_sel, nelc_sel),
                     lim,
                     3'h0,
                     fresh_q,
                     state_q};
        default:
        begin
          rdata_d = 32'h0000_0000;
          err_d   = 1'b1;
        end
      endcase
    end
    else if (psel && !penable && pwrite)
      err_d = (paddr != `ADDR_CTRL);
    else if (psel && penable)
      err_d = pslverr;
  end

  // ==========================================================
  // Output next values
  // ==========================================================
  // The analog controls follow the control word as it will stand after
  // this edge, so they move on the same edge as the write itself.
  logic       ready_d;
  logic       chain_enable_d;
  logic [1:0] cbias_out_d;
  logic [1:0] abias_out_d;
  logic [2:0] osr_out_d;
  logic [1:0] nelc_out_d;
  logic       result_ready_d;

  always_comb
  begin
    ready_d        = 1'b1;
    chain_enable_d = ctrl_d[`CTRL_ENABLE_BIT];
    cbias_out_d    = ctrl_d[`CTRL_CBIAS_LSB +: 2];
    abias_out_d    = ctrl_d[`CTRL_ABIAS_LSB +: 2];
    osr_out_d      = ctrl_d[`CTRL_OSR_LSB +: 3];
    nelc_out_d     = ctrl_d[`CTRL_NELC_LSB +: 2];
    result_ready_d = fresh_d;
  end

  // Outputs reset to shutdown with the lowest codes; the first edge
  // after release copies the control word in.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata                  <= 32'h0000_0000;
      pslverr                 <= 1'b0;
      pready                  <= 1'b1;
      chain_enable            <= 1'b0;
      converter_bias_select   <= 2'b00;
      amplifier_bias_select   <= 2'b00;
      oversampling_select     <= 3'b000;
      elementary_count_select <= 2'b00;
      result_ready            <= 1'b0;
    end
    else
    begin
      prdata                  <= rdata_d;
      pslverr                 <= err_d;
      pready                  <= ready_d;
      chain_enable            <= chain_enable_d;
      converter_bias_select   <= cbias_out_d;
      amplifier_bias_select   <= abias_out_d;
      oversampling_select     <= osr_out_d;
      elementary_count_select <= nelc_out_d;
      result_ready            <= result_ready_d;
    end
  end
endmodule // adc_result_format_and_bias
`default_nettype wire

// [rtl/adc_fmt_defines.svh]
`ifndef ADC_FMT_DEFINES_SVH
`define ADC_FMT_DEFINES_SVH
// Register byte addresses.
`define ADDR_CTRL        12'h000
`define ADDR_RESULT_HIGH 12'h004
`define ADDR_RESULT_LOW  12'h008
`define ADDR_STATUS      12'h00C
`define ADDR_RESULT_WORD 12'h010
`define ADDR_DATA_IN     12'h014
// Control register fields.
`define CTRL_OSR_LSB     2
`define CTRL_NELC_LSB    5
`define CTRL_CBIAS_LSB   8
`define CTRL_ABIAS_LSB   10
`define CTRL_ENABLE_BIT  12
`define CTRL_RESET       32'h0000_0F00
// Result codes and limits.
`define CODE_POS_FULL    16'h7FFF
`define CODE_NEG_FULL    16'h8000
`define RES_MAX_BITS     5'd16
`define OSR_BASE_EXP     4'd3
`define RATE_Q_KHZ_BASE  10'd125
`endif

// [rtl/adc_fmt_pkg.sv]
`default_nettype none
package adc_fmt_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_DONE = 2'b11
  } conv_state_t;
endpackage
`default_nettype wire

// [dv/adc_fmt_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
`include "adc_fmt_defines.svh"
module adc_fmt_assertions (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Modulator strobe and analog controls
  input wire logic        raw_valid,
  input wire logic        chain_enable,
  input wire logic [1:0]  converter_bias_select,
  input wire logic [1:0]  amplifier_bias_select,
  input wire logic [2:0]  oversampling_select,
  input wire logic [1:0]  elementary_count_select,
  // Result flag
  input wire logic        result_ready
);
  // ==========================================================
  // Helpers
  logic [31:0] wd_q;
  always_ff @(posedge ref_clk) wd_q <= pwdata;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_ctrl_wr;
    psel && penable && pwrite && paddr == `ADDR_CTRL;
  endsequence
  sequence s_low_rd;
    psel && penable && !pwrite && paddr == `ADDR_RESULT_LOW && !raw_valid;
  endsequence
  // ==========================================================
  // Checks
  a_ready_high: assert property (pready)
    else $error("pready dropped");
  a_conv_bias: assert property (s_ctrl_wr |=>
    converter_bias_select == wd_q[9:8]) else $error("converter bias");
  a_amp_bias: assert property (s_ctrl_wr |=>
    amplifier_bias_select == wd_q[11:10]) else $error("amplifier bias");
  a_osr_copy: assert property (s_ctrl_wr |=>
    oversampling_select == wd_q[4:2]) else $error("oversampling select");
  a_count_copy: assert property (s_ctrl_wr |=>
    elementary_count_select == wd_q[6:5]) else $error("count select");
  a_enable_copy: assert property (s_ctrl_wr |=>
    chain_enable == wd_q[12]) else $error("chain enable");
  a_ctrl_no_err: assert property (s_ctrl_wr |-> !pslverr)
    else $error("control write refused");
  a_unmapped_err: assert property (psel && penable && !pwrite &&
    paddr == `ADDR_DATA_IN |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped read");
  a_low_clears: assert property (s_low_rd |=> !result_ready)
    else $error("ready not cleared");
endmodule // adc_fmt_assertions
`default_nettype wire

// [dv/adc_result_format_and_bias_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "adc_fmt_defines.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module adc_result_format_and_bias_bench;
  logic        ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic        raw_valid = 0, pready, pslverr, err, chain_enable;
  logic        result_ready;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, ctrl;
  logic [19:0] raw_value = 0;
  logic [1:0]  converter_bias_select, amplifier_bias_select, cb, ab;
  logic [1:0]  elementary_count_select;
  logic [2:0]  oversampling_select;
  logic [7:0]  hi;
  logic [9:0]  lim, fld;
  int          failures = 0, checks_done = 0, res;
  localparam logic [2:0]  T_OSR [7] = '{5, 5, 7, 7, 0, 4, 3};
  localparam logic [1:0]  T_NELC [7] = '{0, 0, 3, 3, 0, 0, 3};
  localparam logic [19:0] T_RAW [7] = '{20'h0_0000, 20'hF_FFFF,
    20'h1_2345, 20'h8_0000, 20'h0_1234, 20'h0_1234, 20'h0_1234};
  adc_result_format_and_bias u_dut (.ref_clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .raw_valid,
    .raw_value, .chain_enable, .converter_bias_select,
    .amplifier_bias_select, .oversampling_select, .elementary_count_select,
    .result_ready);
  initial forever #12.5 ref_clk = ~ref_clk;
  // ==========================================================
  // Bus access; one idle cycle after each keeps drives single.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  function automatic logic [15:0] code_of(logic [19:0] r, int o, int e);
    logic [15:0] c;
    c = ($signed(r) > 20'sh0_7FFF) ? 16'h7FFF :
        ($signed(r) < -20'sh0_8000) ? 16'h8000 : r[15:0];
    for (int b = 0; b < 10 - 2 * o - e; b++)
      c[b] = (b == 9 - 2 * o - e);
    return c;
  endfunction
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    close_out();
  end
  // ==========================================================
  // Tests
  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    `CHK({chain_enable, converter_bias_select}, 3'h0)
    apb(1'b0, `ADDR_CTRL, 32'h0);
    `CHK(rd, `CTRL_RESET)
    apb(1'b0, `ADDR_DATA_IN, 32'h0);
    `CHK({err, rd}, 33'h1_0000_0000)
    apb(1'b1, `ADDR_RESULT_HIGH, 32'hFFFF_FFFF);
    `CHK(err, 1'b1)
    for (int i = 0; i < 7; i++)
    begin
      cb = i[1:0];
      ab = ~i[1:0];
      ctrl = {19'h0, 1'b1, ab, cb, 1'b0, T_NELC[i], T_OSR[i], 2'b00};
      apb(1'b1, `ADDR_CTRL, 32'h0);
      `CHK(chain_enable, 1'b0)
      apb(1'b1, `ADDR_CTRL, ctrl);
      fld = {chain_enable, amplifier_bias_select, converter_bias_select,
             elementary_count_select, oversampling_select};
      `CHK(fld, {ctrl[12:8], ctrl[6:2]})
      res = 2 * (3 + T_OSR[i]) + T_NELC[i];
      if (res > 16) res = 16;
      lim = 10'd125 << ((cb < ab) ? cb : ab);
      apb(1'b0, `ADDR_STATUS, 32'h0);
      `CHK(rd[20:6], {res[4:0], lim})
      `CHK(rd[2:0], 3'b001)
      raw_value <= T_RAW[i];
      raw_valid <= 1'b1;
      @(posedge ref_clk);
      raw_valid <= 1'b0;
      @(posedge ref_clk);
      `CHK(result_ready, 1'b1)
      apb(1'b0, `ADDR_RESULT_HIGH, 32'h0);
      hi = rd[7:0];
      apb(1'b0, `ADDR_RESULT_LOW, 32'h0);
      `CHK({hi, rd[7:0]}, code_of(T_RAW[i], T_OSR[i], T_NELC[i]))
      `CHK(result_ready, 1'b0)
      apb(1'b0, `ADDR_RESULT_WORD, 32'h0);
      `CHK(rd, {16'h0000, code_of(T_RAW[i], T_OSR[i], T_NELC[i])})
      $display("test %0d done", i);
    end
    close_out();
  end
endmodule // adc_result_format_and_bias_bench
bind adc_result_format_and_bias adc_fmt_assertions u_chk (.ref_clk, .rst_n,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .raw_valid, .chain_enable, .converter_bias_select, .amplifier_bias_select,
  .oversampling_select, .elementary_count_select, .result_ready);
`default_nettype wire
